// ===== logic/ppc_cfg_if.sv
// configuration and line level bundle shared between the port and its edge detector
`timescale 1ns/1ps
interface ppc_cfg_if;
  logic [ppc_pkg::LINES-1:0] level;
  logic [ppc_pkg::LINES-1:0] direction;
  logic [ppc_pkg::LINES-1:0] edge_mode;
  logic [ppc_pkg::LINES-1:0] communication_a_select;
  logic [ppc_pkg::LINES-1:0] cpu_req;
  logic [ppc_pkg::LINES-1:0] communication_a_req;
  modport port (output level, direction, edge_mode, communication_a_select, input cpu_req, communication_a_req);
  modport detect (input level, direction, edge_mode, communication_a_select, output cpu_req, communication_a_req);
endinterface : ppc_cfg_if

// ===== logic/ppc_edge_detect.sv
// per-line edge detection producing one-cycle request pulses
`timescale 1ns/1ps
module ppc_edge_detect (
  input wire logic clk_i,
  input wire logic resetn_i,
  ppc_cfg_if.detect cfg
);
  logic [ppc_pkg::LINES-1:0] prev_ff;
  logic [ppc_pkg::LINES-1:0] qualify;
  logic [ppc_pkg::LINES-1:0] cpu_req_ff;
  logic [ppc_pkg::LINES-1:0] communication_a_req_ff;
  logic [ppc_pkg::WARM_EDGES-1:0] warm_ff;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= cfg.level;
    end
  end

  // a pin already high at reset must not look like a rising edge
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      warm_ff <= '0;
    end else begin
      warm_ff <= {warm_ff[ppc_pkg::WARM_EDGES-2:0], 1'b1};
    end
  end

  // mode 0: any change, mode 1: high-to-low only; inputs only
  always_comb begin
    qualify = (prev_ff ^ cfg.level) & ~(cfg.edge_mode & cfg.level) & ~cfg.direction
              & {ppc_pkg::LINES{warm_ff[ppc_pkg::WARM_EDGES-1]}};
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_req_ff <= '0;
      communication_a_req_ff <= '0;
    end else begin
      cpu_req_ff <= qualify & ~cfg.communication_a_select;
      communication_a_req_ff <= qualify & cfg.communication_a_select;
    end
  end

  assign cfg.cpu_req = cpu_req_ff;
  assign cfg.communication_a_req = communication_a_req_ff;
endmodule : ppc_edge_detect

// ===== logic/ppc_pkg.sv
// constants, register map and types for the parallel port with edge requests
package ppc_pkg;
  localparam int LINES = 12;
  localparam int REG_W = 16;
  localparam int ADDR_W = 5;
  // byte offsets on the register bus
  localparam logic [ADDR_W-1:0] OFS_LEVELS = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_ASSIGNMENT = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_SPECIAL = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_EDGE_MODE = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_COMMUNICATION_A_SELECT = 5'h14;
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  // writable bits of each register
  localparam logic [REG_W-1:0] LINE_MASK = 16'h0fff;
  localparam logic [REG_W-1:0] SPECIAL_MASK = 16'h0ff3;
  // carrier-detect selects at 11,9,7,5; clear-to-send at 10,8,6,4
  localparam int CD_BIT0 = 5;
  localparam int CTS_BIT0 = 4;
  localparam int CHANNELS = 4;
  // edges after reset before the edge history holds real pin samples
  localparam int WARM_EDGES = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BRESP = 3'b010,
    ST_RRESP = 3'b100
  } ppc_bus_state_t;
endpackage : ppc_pkg

// ===== logic/ppc_port.sv
// twelve-line parallel port with edge requests and an AXI4-Lite register slave
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module ppc_port (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [ppc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ppc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ppc_pkg::LINES-1:0] port_line_i,
  output logic [ppc_pkg::LINES-1:0] port_line_o,
  output logic [ppc_pkg::LINES-1:0] port_line_oe_n_o,
  input wire logic [ppc_pkg::LINES-1:0] periph_out_i,
  input wire logic [ppc_pkg::LINES-1:0] periph_dir_i,
  output logic [ppc_pkg::LINES-1:0] periph_in_o,
  output logic [ppc_pkg::CHANNELS-1:0] serial_channel_cd_n_o,
  output logic [ppc_pkg::CHANNELS-1:0] serial_channel_cts_n_o,
  output logic [ppc_pkg::LINES-1:0] comm_interrupt_pending_req_o,
  output logic [ppc_pkg::LINES-1:0] communication_a_req_o
);
  logic [ppc_pkg::LINES-1:0] sync1_ff;
  logic [ppc_pkg::LINES-1:0] sync2_ff;
  logic [ppc_pkg::LINES-1:0] latch_ff;
  logic [ppc_pkg::REG_W-1:0] port_line_direction_ff;
  logic [ppc_pkg::REG_W-1:0] port_line_assignment_ff;
  logic [ppc_pkg::REG_W-1:0] port_special_options_ff;
  logic [ppc_pkg::REG_W-1:0] port_edge_mode_ff;
  logic [ppc_pkg::REG_W-1:0] communication_a_select_ff;
  logic [ppc_pkg::LINES-1:0] gp_line;
  logic [ppc_pkg::LINES-1:0] drive;
  ppc_pkg::ppc_bus_state_t state_ff;
  ppc_pkg::ppc_bus_state_t nxt_state;
  logic [ppc_pkg::ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic do_write;
  logic do_read;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [1:0] bresp_ff;
  logic [ppc_pkg::REG_W-1:0] latch_merged;
  logic [31:0] rd_word;
  ppc_cfg_if cfg ();

  // merge byte strobes into a sixteen-bit register under its writable mask
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] val;
    val = old;
    if (strb[0]) begin
      val[7:0] = data[7:0];
    end
    if (strb[1]) begin
      val[15:8] = data[15:8];
    end
    return val & mask;
  endfunction : merge16

  function automatic logic known_addr(input logic [ppc_pkg::ADDR_W-1:0] a);
    return a == ppc_pkg::OFS_LEVELS || a == ppc_pkg::OFS_DIRECTION ||
           a == ppc_pkg::OFS_ASSIGNMENT || a == ppc_pkg::OFS_SPECIAL ||
           a == ppc_pkg::OFS_EDGE_MODE || a == ppc_pkg::OFS_COMMUNICATION_A_SELECT;
  endfunction : known_addr

  // a completed write aimed at one register offset
  function automatic logic write_to(input logic go, input logic [ppc_pkg::ADDR_W-1:0] a,
                                    input logic [ppc_pkg::ADDR_W-1:0] ofs);
    return go && (a == ofs);
  endfunction : write_to

  // a modem input follows its pin only while selected, otherwise it reads asserted
  function automatic logic modem_level(input logic sel, input logic lvl);
    return sel ? lvl : 1'b0;
  endfunction : modem_level

  // two-flop synchroniser on the pin levels
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= port_line_i;
      sync2_ff <= sync1_ff;
    end
  end

  // line muxing: assignment selects peripheral, direction selects output
  always_comb begin
    gp_line = ~port_line_assignment_ff[ppc_pkg::LINES-1:0];
    drive = (gp_line & port_line_direction_ff[ppc_pkg::LINES-1:0]) | (~gp_line & periph_dir_i);
  end

  assign port_line_o = (gp_line & latch_ff) | (~gp_line & periph_out_i);
  assign port_line_oe_n_o = ~drive;
  assign periph_in_o = sync2_ff;

  // serial channel modem inputs, active low, held asserted unless selected
  genvar ch;
  generate
    for (ch = 0; ch < ppc_pkg::CHANNELS; ch++) begin : g_modem
      assign serial_channel_cd_n_o[ch] = modem_level(
          port_special_options_ff[ppc_pkg::CD_BIT0 + 2*ch],
          sync2_ff[ppc_pkg::CD_BIT0 + 2*ch]);
      assign serial_channel_cts_n_o[ch] = modem_level(
          port_special_options_ff[ppc_pkg::CTS_BIT0 + 2*ch],
          sync2_ff[ppc_pkg::CTS_BIT0 + 2*ch]);
    end
  endgenerate

  assign cfg.level = sync2_ff;
  assign cfg.direction = drive;
  assign cfg.edge_mode = port_edge_mode_ff[ppc_pkg::LINES-1:0];
  assign cfg.communication_a_select = communication_a_select_ff[ppc_pkg::LINES-1:0];

  ppc_edge_detect u_edge (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .cfg(cfg)
  );

  assign comm_interrupt_pending_req_o = cfg.cpu_req;
  assign communication_a_req_o = cfg.communication_a_req;

  // write address and data may arrive in either order; each half is held until both are in
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      w_held_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  // reads wait while a write half is held so the two never overlap
  assign s_axi_awready = (state_ff == ppc_pkg::ST_IDLE) && !aw_held_ff;
  assign s_axi_wready = (state_ff == ppc_pkg::ST_IDLE) && !w_held_ff;
  assign s_axi_arready = (state_ff == ppc_pkg::ST_IDLE) && !aw_held_ff && !w_held_ff;
  assign do_write = (state_ff == ppc_pkg::ST_IDLE) && aw_held_ff && w_held_ff;
  assign do_read = s_axi_arvalid && s_axi_arready;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ppc_pkg::ST_IDLE: begin
        if (do_write) begin
          nxt_state = ppc_pkg::ST_BRESP;
        end else if (do_read) begin
          nxt_state = ppc_pkg::ST_RRESP;
        end
      end
      ppc_pkg::ST_BRESP: begin
        if (s_axi_bready) begin
          nxt_state = ppc_pkg::ST_IDLE;
        end
      end
      ppc_pkg::ST_RRESP: begin
        if (s_axi_rready) begin
          nxt_state = ppc_pkg::ST_IDLE;
        end
      end
      default: nxt_state = ppc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= ppc_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // write response: an unmapped offset answers with a slave error and changes nothing
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bresp_ff <= ppc_pkg::RESP_OKAY;
    end else if (do_write) begin
      bresp_ff <= known_addr(awaddr_ff) ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
    end
  end

  // data writes land in the line latch whatever the line direction
  always_comb begin
    latch_merged = merge16({4'h0, latch_ff}, wdata_ff, wstrb_ff, ppc_pkg::LINE_MASK);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_ff <= '0;
    end else if (write_to(do_write, awaddr_ff, ppc_pkg::OFS_LEVELS)) begin
      latch_ff <= latch_merged[ppc_pkg::LINES-1:0];
    end
  end

  // direction: zero input, one output; reserved bits masked off
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_line_direction_ff <= ppc_pkg::REG_RESET;
    end else if (write_to(do_write, awaddr_ff, ppc_pkg::OFS_DIRECTION)) begin
      port_line_direction_ff <= merge16(port_line_direction_ff, wdata_ff, wstrb_ff,
                                        ppc_pkg::LINE_MASK);
    end
  end

  // assignment: zero general I/O, one dedicated function
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_line_assignment_ff <= ppc_pkg::REG_RESET;
    end else if (write_to(do_write, awaddr_ff, ppc_pkg::OFS_ASSIGNMENT)) begin
      port_line_assignment_ff <= merge16(port_line_assignment_ff, wdata_ff, wstrb_ff,
                                         ppc_pkg::LINE_MASK);
    end
  end

  // modem selects; bits 1:0 are stored but drive nothing here
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_special_options_ff <= ppc_pkg::REG_RESET;
    end else if (write_to(do_write, awaddr_ff, ppc_pkg::OFS_SPECIAL)) begin
      port_special_options_ff <= merge16(port_special_options_ff, wdata_ff, wstrb_ff,
                                         ppc_pkg::SPECIAL_MASK);
    end
  end

  // edge mode per line
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_edge_mode_ff <= ppc_pkg::REG_RESET;
    end else if (write_to(do_write, awaddr_ff, ppc_pkg::OFS_EDGE_MODE)) begin
      port_edge_mode_ff <= merge16(port_edge_mode_ff, wdata_ff, wstrb_ff,
                                   ppc_pkg::LINE_MASK);
    end
  end

  // lines whose requests go to the communication processor
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      communication_a_select_ff <= ppc_pkg::REG_RESET;
    end else if (write_to(do_write, awaddr_ff, ppc_pkg::OFS_COMMUNICATION_A_SELECT)) begin
      communication_a_select_ff <= merge16(communication_a_select_ff, wdata_ff, wstrb_ff,
                                ppc_pkg::LINE_MASK);
    end
  end

  // read word for the offset on the address channel; levels are the synchronised pins
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      ppc_pkg::OFS_LEVELS: rd_word = {20'h0_0000, sync2_ff};
      ppc_pkg::OFS_DIRECTION: rd_word = {16'h0000, port_line_direction_ff};
      ppc_pkg::OFS_ASSIGNMENT: rd_word = {16'h0000, port_line_assignment_ff};
      ppc_pkg::OFS_SPECIAL: rd_word = {16'h0000, port_special_options_ff};
      ppc_pkg::OFS_EDGE_MODE: rd_word = {16'h0000, port_edge_mode_ff};
      ppc_pkg::OFS_COMMUNICATION_A_SELECT: rd_word = {16'h0000, communication_a_select_ff};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // read response taken on the address handshake
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rresp_ff <= ppc_pkg::RESP_OKAY;
    end else if (do_read) begin
      rresp_ff <= known_addr(s_axi_araddr) ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
    end
  end

  // read data captured on the address handshake and held until taken
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= '0;
    end else if (do_read) begin
      rdata_ff <= rd_word;
    end
  end

  // responses stand from the state register until the master takes them
  assign s_axi_bvalid = (state_ff == ppc_pkg::ST_BRESP);
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = (state_ff == ppc_pkg::ST_RRESP);
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule : ppc_port

// ===== verif/ppc_pin_model.sv
// behavioural outside drivers facing the port lines
`timescale 1ns/1ps
module ppc_pin_model (
  input wire logic [ppc_pkg::LINES-1:0] ext_level_i,
  input wire logic [ppc_pkg::LINES-1:0] drive_i,
  input wire logic [ppc_pkg::LINES-1:0] drive_oe_n_i,
  output logic [ppc_pkg::LINES-1:0] line_o
);
  // a line the port drives shows the port's value, otherwise the outside level
  assign line_o = (drive_oe_n_i & ext_level_i) | (~drive_oe_n_i & drive_i);
endmodule : ppc_pin_model

// ===== verif/ppc_port_sva.sv
// concurrent checks on the parallel port top-level ports
`timescale 1ns/1ps
module ppc_port_sva (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [ppc_pkg::LINES-1:0] port_line_i,
  input wire logic [ppc_pkg::LINES-1:0] port_line_oe_n_o,
  input wire logic [ppc_pkg::CHANNELS-1:0] serial_channel_cd_n_o,
  input wire logic [ppc_pkg::CHANNELS-1:0] serial_channel_cts_n_o,
  input wire logic [ppc_pkg::LINES-1:0] comm_interrupt_pending_req_o,
  input wire logic [ppc_pkg::LINES-1:0] communication_a_req_o
);
  logic [47:0] hist_ff;
  logic [11:0] held, moved;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // pin history, newest sample in the low slice
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) hist_ff <= '0;
    else hist_ff <= {hist_ff[35:0], port_line_i};
  end
  assign held = hist_ff[23:12] | hist_ff[35:24];
  assign moved = hist_ff[35:24] ^ hist_ff[47:36];
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_req_seen;
    (comm_interrupt_pending_req_o | communication_a_req_o) != '0;
  endsequence
  property p_read_answer;
    s_ar_take |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer missing");
  property p_rdata_top;
    s_axi_rvalid |-> s_axi_rdata[31:12] == '0;
  endproperty
  a_rdata_top: assert property (p_rdata_top) else $error("upper read bits set");
  property p_oe_reset;
    $rose(resetn_i) |-> port_line_oe_n_o == '1;
  endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("line driven after reset");
  property p_req_pulse;
    s_req_seen |=> ((comm_interrupt_pending_req_o | communication_a_req_o)
      & $past(comm_interrupt_pending_req_o | communication_a_req_o)) == '0;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request wider than one cycle");
  property p_req_cause;
    s_req_seen |-> ((comm_interrupt_pending_req_o | communication_a_req_o) & ~moved) == '0;
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("request without pin change");
  property p_route_excl;
    s_req_seen |-> (comm_interrupt_pending_req_o & communication_a_req_o) == '0;
  endproperty
  a_route_excl: assert property (p_route_excl) else $error("request on both routes");
  property p_cd_level;
    (serial_channel_cd_n_o & ~{held[11], held[9], held[7], held[5]}) == '0;
  endproperty
  a_cd_level: assert property (p_cd_level) else $error("carrier detect negated wrongly");
  property p_cts_level;
    (serial_channel_cts_n_o & ~{held[10], held[8], held[6], held[4]}) == '0;
  endproperty
  a_cts_level: assert property (p_cts_level) else $error("clear to send negated wrongly");
endmodule : ppc_port_sva

bind ppc_port ppc_port_sva i_ppc_port_sva (
  .clk_i(clk_i), .resetn_i(resetn_i), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .port_line_i(port_line_i), .port_line_oe_n_o(port_line_oe_n_o),
  .serial_channel_cd_n_o(serial_channel_cd_n_o), .serial_channel_cts_n_o(serial_channel_cts_n_o),
  .comm_interrupt_pending_req_o(comm_interrupt_pending_req_o),
  .communication_a_req_o(communication_a_req_o)
);

// ===== verif/tb.sv
// self-checking bench for the parallel port: registers, line requests, pin routing
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [3:0] strb = 4'hf;
  logic [11:0] pout = '0, pdir = '0;
  logic [1:0] bq [$];
  logic [11:0] ext = '0, port_line_i, port_line_o, port_line_oe_n_o, periph_in_o;
  logic [11:0] comm_interrupt_pending_req_o, communication_a_req_o, mode, sel, so, nv, e;
  logic [3:0] serial_channel_cd_n_o, serial_channel_cts_n_o;
  logic [15:0] msk [1:5] = '{16'h0fff, 16'h0fff, 16'h0ff3, 16'h0fff, 16'h0fff};
  logic [33:0] rq [$];
  logic [33:0] r_exp;
  logic [23:0] iq [$];
  int failures = 0, checks_done = 0, cyc = 0;
  integer seed = 32'heb49f62c;
  ppc_port i_ppc_port (.clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .port_line_i(port_line_i), .port_line_o(port_line_o),
    .port_line_oe_n_o(port_line_oe_n_o), .periph_out_i(pout), .periph_dir_i(pdir),
    .periph_in_o(periph_in_o), .serial_channel_cd_n_o(serial_channel_cd_n_o),
    .serial_channel_cts_n_o(serial_channel_cts_n_o),
    .comm_interrupt_pending_req_o(comm_interrupt_pending_req_o),
    .communication_a_req_o(communication_a_req_o));
  ppc_pin_model i_ppc_pin_model (.ext_level_i(ext), .drive_i(port_line_o),
    .drive_oe_n_i(port_line_oe_n_o), .line_o(port_line_i));
  initial forever #25 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic ta, tw, tb_seen;
    bq.push_back((a > ppc_pkg::OFS_COMMUNICATION_A_SELECT || a[1:0] != 2'b00) ? ppc_pkg::RESP_SLVERR
      : ppc_pkg::RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb_seen = s_axi_bvalid;
      @(posedge clk_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb_seen);
    s_axi_bready <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic ta, tr;
    rq.push_back({resp, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      @(posedge clk_i);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
    s_axi_rready <= 1'b0;
    @(posedge clk_i);
  endtask : rd
  task automatic wrap_up();
    failures += rq.size() + iq.size() + bq.size();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  // results are compared against the oldest noted expectation
  always @(negedge clk_i) begin
    if (s_axi_rvalid && s_axi_rready) begin
      r_exp = rq.pop_front();
      chk(s_axi_rdata, r_exp[31:0], "read data");
      chk(32'(s_axi_rresp), 32'(r_exp[33:32]), "read response");
    end
    if (s_axi_bvalid && s_axi_bready)
      chk(32'(s_axi_bresp), 32'(bq.size() > 0 ? bq.pop_front() : 2'b11),
        "write response");
    if ((comm_interrupt_pending_req_o | communication_a_req_o) != '0)
      chk({communication_a_req_o, comm_interrupt_pending_req_o},
        iq.size() > 0 ? iq.pop_front() : 24'h00_0000, "requests");
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    wr(5'h18, 32'hffff_ffff);
    for (int i = 0; i < 7; i++)
      rd(5'(i * 4), 32'h0000_0000, i == 6 ? 2'b10 : 2'b00);
    for (int i = 1; i < 6; i++) begin
      wr(5'(i * 4), 32'hffff_ffff);
      rd(5'(i * 4), {16'h0000, msk[i]}, 2'b00);
      wr(5'(i * 4), 32'h0000_0000);
    end
    strb <= 4'h1;
    wr(5'h04, 32'hffff_ffff);
    strb <= 4'hf;
    rd(5'h04, 32'h0000_00ff, 2'b00);
    wr(5'h04, 32'h0000_0000);
    $display("test registers done");
    for (int r = 0; r < 4; r++) begin
      mode = 12'($random(seed));
      sel = 12'($random(seed));
      so = 12'($random(seed)) & 12'hff3;
      wr(5'h10, {20'h0_0000, mode});
      wr(5'h14, {20'h0_0000, sel});
      wr(5'h0c, {20'h0_0000, so});
      repeat (8) begin
        nv = 12'($random(seed));
        e = (ext ^ nv) & (~mode | (ext & ~nv));
        if (e != '0) iq.push_back({e & sel, e & ~sel});
        ext <= nv;
        repeat (6) @(posedge clk_i);
        rd(5'h00, {20'h0_0000, nv}, 2'b00);
        chk(32'(periph_in_o), 32'(nv), "peripheral input");
        chk(32'({nv[11], nv[9], nv[7], nv[5]} & {so[11], so[9], so[7], so[5]}),
          32'(serial_channel_cd_n_o), "carrier detect");
        chk(32'({nv[10], nv[8], nv[6], nv[4]} & {so[10], so[8], so[6], so[4]}),
          32'(serial_channel_cts_n_o), "clear to send");
      end
    end
    $display("test line requests done");
    wr(5'h00, 32'h0000_0a5a);
    wr(5'h04, 32'h0000_00f0);
    repeat (2) begin
      repeat (6) @(posedge clk_i);
      chk(32'(port_line_oe_n_o), 32'h0000_0f0f, "drive enables");
      rd(5'h00, {20'h0_0000, 12'h050 | (ext & 12'hf0f)}, 2'b00);
      ext <= ext ^ 12'h0f0;
    end
    repeat (6) @(posedge clk_i);
    pout <= 12'($random(seed));
    pdir <= 12'h003;
    wr(5'h08, 32'h0000_000f);
    repeat (6) @(posedge clk_i);
    chk(32'(port_line_oe_n_o), 32'h0000_0f0c, "dedicated enables");
    chk(32'(port_line_o & 12'h003), 32'(pout & 12'h003), "dedicated drive");
    $display("test output lines done");
    wrap_up();
  end
endmodule : tb
